// >>> src/dit_pkg.sv
`default_nettype none
package dit_pkg;
  // ---------------------------------------------------------------
  // register map (byte addresses, one word each)
  // ---------------------------------------------------------------
  localparam logic [7:0] ADR_CLKSEL     = 8'h00;
  localparam logic [7:0] ADR_COMPARE1   = 8'h04;
  localparam logic [7:0] ADR_COMPARE2   = 8'h08;
  localparam logic [7:0] ADR_COUNTER1   = 8'h0c;
  localparam logic [7:0] ADR_COUNTER2   = 8'h10;
  localparam logic [7:0] ADR_CONTROL    = 8'h14;
  localparam logic [7:0] ADR_IRQ_STATUS = 8'h18;
  localparam logic [7:0] ADR_IRQ_CLEAR  = 8'h1c;
  localparam logic [7:0] ADR_IRQ_ENABLE = 8'h20;
  // ---------------------------------------------------------------
  // field positions
  // ---------------------------------------------------------------
  localparam int CTL_RUN_ONE  = 0;
  localparam int CTL_RUN_TWO  = 1;
  localparam int CTL_OSC_MODE = 2;
  localparam int IRQ_ONE      = 0;
  localparam int IRQ_TWO      = 1;
  localparam int SEL_ONE_LSB  = 0;
  localparam int SEL_TWO_LSB  = 4;
  // ---------------------------------------------------------------
  // reset values
  // ---------------------------------------------------------------
  localparam logic [7:0] RST_CLKSEL  = 8'h00;
  localparam logic [7:0] RST_COMPARE = 8'h00;
  localparam logic [2:0] RST_CONTROL = 3'h0;
  localparam logic [1:0] RST_IRQ     = 2'h0;
  // ---------------------------------------------------------------
  // clock-select codes and prescaler
  // ---------------------------------------------------------------
  localparam logic [3:0] CODE_EXT_FALL = 4'h0;
  localparam logic [3:0] CODE_EXT_RISE = 4'h1;
  localparam logic [3:0] CODE_TAP_LO   = 4'h6;
  localparam logic [3:0] CODE_TAP_HI   = 4'he;
  localparam logic [3:0] CODE_TAP_TOP  = 4'hf;
  localparam logic [3:0] TAP_BASE      = 4'h5;
  localparam logic [3:0] TAP_TOP_SHIFT = 4'hb;
  localparam int         PRESC_W       = 12;

  // shift 0 means no prescaled tick (external or prohibited code)
  function automatic logic [3:0] dit_tap(input logic [3:0] code,
                                         input logic       osc_mode);
    logic [3:0] slow;
    slow = osc_mode ? 4'h0 : 4'h1;
    if (code >= CODE_TAP_LO && code <= CODE_TAP_HI)
      dit_tap = code - TAP_BASE + slow;
    else if (code == CODE_TAP_TOP)
      dit_tap = TAP_TOP_SHIFT + slow;
    else
      dit_tap = 4'h0;
  endfunction
endpackage
`default_nettype wire

// >>> src/dit_top.sv
// Overview of operation
// (R1) each counter repeats its interrupt once per period set by its compare
// (R2) on equality the counter clears to 0, keeps counting, raises its request
// (R3) clock-select bits 3..0 pick counter one's count clock
// (R4) clock-select bits 7..4 pick counter two's count clock
// (R5) period is compare plus one count-clock periods, compare 00h..ffh
// (R6) codes 0/1 external edges, 6..14 taps 2^1..2^9, 15 tap 2^11
// (R7) mode bit picks full or half oscillator as base of all taps
// (R8) software stops a timer before changing its clock selection
`default_nettype none

// ---------------------------------------------------------------
// one counter channel
// ---------------------------------------------------------------
module dit_channel
  import dit_pkg::*;
#(
  parameter int W = 8
) (
  input  wire logic               clock,
  input  wire logic               resetn,
  input  wire logic               run,
  input  wire logic [3:0]         code,
  input  wire logic               osc_mode,
  input  wire logic [PRESC_W-1:0] presc,
  input  wire logic               ext_in,
  input  wire logic [W-1:0]       compare,
  output logic      [W-1:0]       count,
  output logic                    match
);
  import dit_pkg::*;

  logic               ext_prev;
  logic [3:0]         shift;
  logic [PRESC_W-1:0] mask;
  logic               tap_tick;
  logic               ext_rise;
  logic               ext_fall;
  logic               ext_tick;
  logic               tick;
  logic               equal;
  logic [W-1:0]       next_count;

  assign shift    = dit_tap(code, osc_mode); // (R6) (R7)
  assign mask     = PRESC_W'((13'h0001 << shift) - 13'h0001);
  assign tap_tick = (shift != 4'h0) && ((presc & mask) == mask);
  assign ext_rise = ext_in & ~ext_prev;
  assign ext_fall = ~ext_in & ext_prev;
  assign ext_tick = (code == CODE_EXT_RISE) ? ext_rise :
                    (code == CODE_EXT_FALL) ? ext_fall : 1'b0; // (R6)
  assign tick     = run & (tap_tick | ext_tick);
  assign equal    = (count == compare);
  // clear and continue, so the period is compare plus one ticks
  assign next_count = equal ? '0 : W'(count + 1'b1); // (R2) (R5)

  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      ext_prev <= 1'b0;
      count    <= '0;
      match    <= 1'b0;
    end else begin
      ext_prev <= ext_in;
      match    <= tick & equal; // (R1) (R2)
      if (!run) begin
        count <= '0;
      end else if (tick) begin
        count <= next_count; // (R2)
      end
    end
  end
endmodule

// ---------------------------------------------------------------
// top: wishbone slave, prescaler, two channels, interrupts
// ---------------------------------------------------------------
module dit_top
  import dit_pkg::*;
#(
  parameter int W = 8
) (
  input  wire logic        clock,
  input  wire logic        resetn,
  input  wire logic        wb_cyc_i,
  input  wire logic        wb_stb_i,
  input  wire logic        wb_we_i,
  input  wire logic [7:0]  wb_adr_i,
  input  wire logic [3:0]  wb_sel_i,
  input  wire logic [31:0] wb_dat_i,
  output logic      [31:0] wb_dat_o,
  output logic             wb_ack_o,
  input  wire logic        ext_count_input_one,
  input  wire logic        ext_count_input_two,
  output logic             match_irq_one,
  output logic             match_irq_two,
  output logic             irq
);
  import dit_pkg::*;

  logic [7:0]         timer_clock_select;
  logic [W-1:0]       compare_one;
  logic [W-1:0]       compare_two;
  logic [2:0]         control;
  logic [1:0]         irq_status;
  logic [1:0]         irq_enable;
  logic [PRESC_W-1:0] presc;
  logic [W-1:0]       counter_one;
  logic [W-1:0]       counter_two;
  logic               hit_one;
  logic               hit_two;

  // ---------------------------------------------------------------
  // bus decode
  // ---------------------------------------------------------------
  logic        req;
  logic        wr;
  logic        wr_clksel;
  logic        wr_cmp1;
  logic        wr_cmp2;
  logic        wr_ctl;
  logic        wr_clr;
  logic        wr_en;
  logic [1:0]  clr_bits;
  logic [1:0]  events;
  logic [31:0] rd_mux;
  logic        osc_mode_bit;

  assign req       = wb_cyc_i & wb_stb_i & ~wb_ack_o;
  assign wr        = req & wb_we_i & wb_sel_i[0];
  assign wr_clksel = wr & (wb_adr_i == ADR_CLKSEL);
  assign wr_cmp1   = wr & (wb_adr_i == ADR_COMPARE1);
  assign wr_cmp2   = wr & (wb_adr_i == ADR_COMPARE2);
  assign wr_ctl    = wr & (wb_adr_i == ADR_CONTROL);
  assign wr_clr    = wr & (wb_adr_i == ADR_IRQ_CLEAR);
  assign wr_en     = wr & (wb_adr_i == ADR_IRQ_ENABLE);
  assign clr_bits  = wr_clr ? wb_dat_i[1:0] : 2'b00;
  assign events    = {hit_two, hit_one};
  assign osc_mode_bit = control[CTL_OSC_MODE];

  assign rd_mux =
    (wb_adr_i == ADR_CLKSEL)     ? {24'h0, timer_clock_select} :
    (wb_adr_i == ADR_COMPARE1)   ? 32'(compare_one) :
    (wb_adr_i == ADR_COMPARE2)   ? 32'(compare_two) :
    (wb_adr_i == ADR_COUNTER1)   ? 32'(counter_one) :
    (wb_adr_i == ADR_COUNTER2)   ? 32'(counter_two) :
    (wb_adr_i == ADR_CONTROL)    ? {29'h0, control} :
    (wb_adr_i == ADR_IRQ_STATUS) ? {30'h0, irq_status} :
    (wb_adr_i == ADR_IRQ_ENABLE) ? {30'h0, irq_enable} : 32'h0;

  // ---------------------------------------------------------------
  // registers
  // ---------------------------------------------------------------
  // selection is taken as written; a running timer sees it at once,
  // so a change mid-count may give one odd period
  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      timer_clock_select <= RST_CLKSEL;
      compare_one        <= W'(RST_COMPARE);
      compare_two        <= W'(RST_COMPARE);
      control            <= RST_CONTROL;
      irq_enable         <= RST_IRQ;
    end else begin
      if (wr_clksel) timer_clock_select <= wb_dat_i[7:0]; // (R8)
      if (wr_cmp1)   compare_one        <= wb_dat_i[W-1:0];
      if (wr_cmp2)   compare_two        <= wb_dat_i[W-1:0];
      if (wr_ctl)    control            <= wb_dat_i[2:0];
      if (wr_en)     irq_enable         <= wb_dat_i[1:0];
    end
  end

  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      wb_ack_o <= 1'b0;
      wb_dat_o <= 32'h0;
    end else begin
      wb_ack_o <= req;
      wb_dat_o <= (req & ~wb_we_i) ? rd_mux : 32'h0;
    end
  end

  // ---------------------------------------------------------------
  // prescaler
  // ---------------------------------------------------------------
  // one free-running divider serves both channels, so taps stay
  // phase-aligned between them
  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      presc <= '0;
    end else begin
      presc <= PRESC_W'(presc + 1'b1); // (R7)
    end
  end

  // ---------------------------------------------------------------
  // channels
  // ---------------------------------------------------------------
  dit_channel #(.W(W)) u_one (
    .clock    (clock),
    .resetn   (resetn),
    .run      (control[CTL_RUN_ONE]),
    .code     (timer_clock_select[SEL_ONE_LSB +: 4]), // (R3)
    .osc_mode (osc_mode_bit),
    .presc    (presc),
    .ext_in   (ext_count_input_one),
    .compare  (compare_one),
    .count    (counter_one),
    .match    (hit_one)
  );

  dit_channel #(.W(W)) u_two (
    .clock    (clock),
    .resetn   (resetn),
    .run      (control[CTL_RUN_TWO]),
    .code     (timer_clock_select[SEL_TWO_LSB +: 4]), // (R4)
    .osc_mode (osc_mode_bit),
    .presc    (presc),
    .ext_in   (ext_count_input_two),
    .compare  (compare_two),
    .count    (counter_two),
    .match    (hit_two)
  );

  // ---------------------------------------------------------------
  // interrupts
  // ---------------------------------------------------------------
  // set beats clear so a match in the clearing cycle survives
  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      irq_status    <= RST_IRQ;
      irq           <= 1'b0;
      match_irq_one <= 1'b0;
      match_irq_two <= 1'b0;
    end else begin
      irq_status    <= (irq_status & ~clr_bits) | events; // (R1)
      irq           <= |(irq_status & irq_enable);
      match_irq_one <= hit_one; // (R2)
      match_irq_two <= hit_two; // (R2)
    end
  end
endmodule
`default_nettype wire

// >>> verification/dit_props.sv
`default_nettype none
module dit_props (
  input wire logic        clock,
  input wire logic        resetn,
  input wire logic        wb_cyc_i,
  input wire logic        wb_stb_i,
  input wire logic        wb_ack_o,
  input wire logic [31:0] wb_dat_o,
  input wire logic        match_irq_one,
  input wire logic        match_irq_two,
  input wire logic        irq
);
  default clocking cb @(posedge clock); endclocking
  default disable iff (!resetn);
  AST_ACK_LAT: assert property (
    wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o) else $error("no ack");
  AST_ACK_PULSE: assert property (
    wb_ack_o |=> !wb_ack_o) else $error("ack too long");
  AST_DAT_IDLE: assert property (
    !wb_ack_o |-> wb_dat_o == 32'h0) else $error("data outside ack");
  AST_DAT_UPPER: assert property (
    wb_ack_o |-> wb_dat_o[31:8] == 24'h0) else $error("upper bits set");
  AST_ONE_PULSE: assert property (
    match_irq_one |=> !match_irq_one) else $error("match one too long");
  AST_TWO_PULSE: assert property (
    match_irq_two |=> !match_irq_two) else $error("match two too long");
  AST_IRQ_RISE: assert property (
    $rose(irq) |-> $past(match_irq_one) || $past(match_irq_two)
      || $past(wb_ack_o)) else $error("irq rose without cause");
  AST_IRQ_FALL: assert property (
    $fell(irq) |-> $past(wb_ack_o)) else $error("irq fell without write");
  COV_ONE: cover property (match_irq_one);
  COV_TWO: cover property (match_irq_two);
  COV_IRQ: cover property ($rose(irq));
endmodule
bind dit_top dit_props u_props (.clock(clock), .resetn(resetn),
  .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i), .wb_ack_o(wb_ack_o),
  .wb_dat_o(wb_dat_o), .match_irq_one(match_irq_one),
  .match_irq_two(match_irq_two), .irq(irq));
`default_nettype wire

// >>> verification/dual_8bit_interval_timer_tb_top.sv
`default_nettype none
module dual_8bit_interval_timer_tb_top;
  timeunit 1ns;
  timeprecision 1ns;
  import dit_pkg::*;
  logic        clock = 0, resetn = 0, cyc = 0, stb = 0, we = 0;
  logic        ext1 = 0, ext2 = 0, ack, m1, m2, irq;
  logic [7:0]  adr = 8'h0;
  logic [3:0]  sel = 4'h0;
  logic [31:0] dw = 32'h0, dr;
  int          err_count = 0, compares = 0, cycles = 0;
  // ---------------------------------------------------------------
  // clock, timeout
  // ---------------------------------------------------------------
  initial forever #25 clock = ~clock;
  always @(posedge clock) begin
    cycles++;
    if (cycles == 20000) begin
      err_count++;
      complete_run();
    end
  end
  dit_top uut (.clock(clock), .resetn(resetn), .wb_cyc_i(cyc),
    .wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(sel),
    .wb_dat_i(dw), .wb_dat_o(dr), .wb_ack_o(ack),
    .ext_count_input_one(ext1), .ext_count_input_two(ext2),
    .match_irq_one(m1), .match_irq_two(m2), .irq(irq));
  // ---------------------------------------------------------------
  // tasks
  // ---------------------------------------------------------------
  task automatic complete_run();
    if (err_count == 0 && compares > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    compares++;
    if (seen !== exp) begin
      err_count++;
      $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
    end
  endtask
  // holds the request until ack is sampled high, then releases
  task automatic wb(input logic [7:0] a, input logic w,
                    input logic [31:0] d, output logic [31:0] q);
    @(posedge clock);
    cyc <= 1'b1;
    stb <= 1'b1;
    we  <= w;
    adr <= a;
    sel <= 4'hf;
    dw  <= d;
    do @(posedge clock); while (ack !== 1'b1);
    q = dr;
    cyc <= 1'b0;
    stb <= 1'b0;
  endtask
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    logic [31:0] q;
    wb(a, 1'b1, {24'h0, d}, q);
  endtask
  task automatic rd(input logic [7:0] a, input logic [7:0] e);
    logic [31:0] q;
    wb(a, 1'b0, 32'h0, q);
    check(q, {24'h0, e});
  endtask
  // clocks between two match pulses of one counter
  task automatic period(input logic two, input int exp);
    int n;
    n = 0;
    do @(posedge clock); while ((two ? m2 : m1) !== 1'b1);
    do begin
      @(posedge clock);
      n++;
    end while ((two ? m2 : m1) !== 1'b1);
    check(n, exp);
  endtask
  task automatic pulse(input int n);
    repeat (n) begin
      ext1 <= 1'b1;
      ext2 <= 1'b1;
      repeat (3) @(posedge clock);
      ext1 <= 1'b0;
      ext2 <= 1'b0;
      repeat (3) @(posedge clock);
    end
  endtask
  // ---------------------------------------------------------------
  // sequence
  // ---------------------------------------------------------------
  initial begin
    repeat (10) @(posedge clock);
    resetn <= 1'b1;
    rd(ADR_CLKSEL, RST_CLKSEL);
    rd(ADR_COMPARE1, RST_COMPARE);
    rd(ADR_CONTROL, 8'h0);
    rd(ADR_IRQ_STATUS, 8'h0);
    rd(8'h40, 8'h0);
    wr(ADR_CLKSEL, 8'h76);
    wr(ADR_COMPARE1, 8'h02);
    wr(ADR_COMPARE2, 8'h01);
    wr(ADR_CONTROL, 8'h07);
    period(1'b0, 6);
    period(1'b1, 8);
    // stop first so no pulse of the old rate leaks into the next period
    wr(ADR_CONTROL, 8'h00);
    wr(ADR_CONTROL, 8'h03);
    period(1'b0, 12);
    period(1'b1, 16);
    wr(ADR_CONTROL, 8'h00);
    wr(ADR_COMPARE1, 8'hff);
    wr(ADR_CONTROL, 8'h05);
    period(1'b0, 512);
    wr(ADR_CONTROL, 8'h00);
    wr(ADR_CLKSEL, 8'h0f);
    wr(ADR_COMPARE1, 8'h00);
    wr(ADR_CONTROL, 8'h05);
    period(1'b0, 2048);
    wr(ADR_CONTROL, 8'h00);
    wr(ADR_CLKSEL, 8'h02);
    wr(ADR_CONTROL, 8'h05);
    repeat (60) @(posedge clock);
    rd(ADR_COUNTER1, 8'h00);
    wr(ADR_CONTROL, 8'h00);
    wr(ADR_CLKSEL, 8'h11);
    wr(ADR_COMPARE1, 8'h03);
    wr(ADR_COMPARE2, 8'h03);
    wr(ADR_CONTROL, 8'h03);
    pulse(3);
    rd(ADR_COUNTER1, 8'h03);
    rd(ADR_COUNTER2, 8'h03);
    pulse(1);
    rd(ADR_COUNTER1, 8'h00);
    wr(ADR_CONTROL, 8'h00);
    wr(ADR_CLKSEL, 8'h00);
    wr(ADR_CONTROL, 8'h01);
    ext1 <= 1'b1;
    repeat (3) @(posedge clock);
    rd(ADR_COUNTER1, 8'h00);
    ext1 <= 1'b0;
    repeat (3) @(posedge clock);
    rd(ADR_COUNTER1, 8'h01);
    wr(ADR_CONTROL, 8'h00);
    rd(ADR_IRQ_STATUS, 8'h03);
    check(irq, 1'b0);
    wr(ADR_IRQ_ENABLE, 8'h02);
    @(posedge clock);
    check(irq, 1'b1);
    wr(ADR_IRQ_CLEAR, 8'h02);
    @(posedge clock);
    check(irq, 1'b0);
    rd(ADR_IRQ_STATUS, 8'h01);
    complete_run();
  end
endmodule
`default_nettype wire
